/* design/dpsc_port_ctrl.sv */
// Host-side controller that drives one port of the dual-port SRAM through its pins.
module dpsc_port_ctrl #(
  parameter int unsigned AW = 15,
  parameter int unsigned DW = 16
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // User command port.
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_op,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [DW-1:0] cmd_wdata,
  input wire logic [1:0] cmd_be,
  output logic cmd_ready,
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  output logic rsp_granted,
  // SRAM pins.
  output logic chip_select_n,
  output logic token_space_select_n,
  output logic write_strobe_n,
  output logic output_enable_n,
  output logic upper_byte_select_n,
  output logic lower_byte_select_n,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] data_out,
  output logic data_oe,
  input wire logic [DW-1:0] data_in
);
  import dpsc_pkg::*;

  // Refuse widths, and write pulse, recovery and read cycle counts, that the pin logic or the timer cannot hold.
  if (AW < 1 || DW != 16 || WP_CYC >= (1 << CNT_W) || WREC_CYC >= (1 << CNT_W) ||
      RD_CYC + 3 >= (1 << CNT_W)) begin : g_param_check
    $error("dpsc_port_ctrl: unsupported parameters");
  end

  typedef enum logic [6:0] {
    DPSC_IDLE = 7'h01,
    DPSC_SETUP = 7'h02,
    DPSC_WPULSE = 7'h04,
    DPSC_WREC = 7'h08,
    DPSC_GAP = 7'h10,
    DPSC_RD = 7'h20,
    DPSC_RDEND = 7'h40
  } dpsc_state_e;

  dpsc_state_e st_r, st_nxt;
  logic cs_n_r, cs_n_nxt, ts_n_r, ts_n_nxt, we_n_r, we_n_nxt, oe_n_r, oe_n_nxt;
  logic ub_n_r, ub_n_nxt, lb_n_r, lb_n_nxt, doe_r, doe_nxt;
  logic [AW-1:0] addr_r, addr_nxt;
  logic [DW-1:0] dout_r, dout_nxt, rdat_r, rdat_nxt;
  logic rv_r, rv_nxt, gr_r, gr_nxt, tok_r, tok_nxt, chk_r, chk_nxt;
  logic t_load, t_done;
  logic [CNT_W-1:0] t_val;
  logic [DW-1:0] din_s1_r, din_s2_r, din_s3_r;

  // Read data passes three flops; the value counts once the last two agree.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      din_s1_r <= RESET_DATA;
      din_s2_r <= RESET_DATA;
      din_s3_r <= RESET_DATA;
    end else begin
      din_s1_r <= data_in;
      din_s2_r <= din_s1_r;
      din_s3_r <= din_s2_r;
    end
  end

  dpsc_cycle_timer #(.WIDTH(CNT_W)) u_timer (
    .ref_clk(ref_clk),
    .reset(reset),
    .load(t_load),
    .load_val(t_val),
    .done(t_done)
  );

  // Sequencer for write, read and token cycles.
  always_comb begin
    st_nxt = st_r;
    cs_n_nxt = cs_n_r;
    ts_n_nxt = ts_n_r;
    we_n_nxt = we_n_r;
    oe_n_nxt = oe_n_r;
    ub_n_nxt = ub_n_r;
    lb_n_nxt = lb_n_r;
    doe_nxt = doe_r;
    addr_nxt = addr_r;
    dout_nxt = dout_r;
    rdat_nxt = rdat_r;
    rv_nxt = 1'b0;
    gr_nxt = gr_r;
    tok_nxt = tok_r;
    chk_nxt = chk_r;
    t_load = 1'b0;
    t_val = '0;
    case (st_r)
      DPSC_IDLE: begin
        if (cmd_valid) begin
          // Address moves only with every select and strobe high.
          addr_nxt = cmd_addr;
          tok_nxt = cmd_op[1];
          chk_nxt = (cmd_op == CMD_TOKEN_GET);
          // Output enable stays high during writes, though the pulse is still sized for T_WZ_NS plus T_DW_NS.
          oe_n_nxt = 1'b1;
          if (cmd_op == CMD_RD) begin
            st_nxt = DPSC_RD;
            cs_n_nxt = 1'b0;
            ub_n_nxt = ~cmd_be[1];
            lb_n_nxt = ~cmd_be[0];
            oe_n_nxt = 1'b0;
            t_load = 1'b1;
            t_val = CNT_W'(RD_CYC + 2);
          end else begin
            st_nxt = DPSC_SETUP;
            // Token get writes zero on bit 0, release writes one.
            dout_nxt = cmd_op[1] ? {{(DW-1){1'b0}}, (cmd_op == CMD_TOKEN_FREE)} : cmd_wdata;
            ub_n_nxt = cmd_op[1] ? 1'b0 : ~cmd_be[1];
            lb_n_nxt = cmd_op[1] ? 1'b0 : ~cmd_be[0];
            t_load = 1'b1;
            t_val = CNT_W'(HZ_CYC);
          end
        end
      end
      DPSC_SETUP: begin
        // Chip or token select falls with the strobe so the RAM keeps its pins floating; byte selects fell at accept.
        if (t_done) begin
          st_nxt = DPSC_WPULSE;
          we_n_nxt = 1'b0;
          doe_nxt = 1'b1;
          cs_n_nxt = tok_r;
          ts_n_nxt = ~tok_r;
          t_load = 1'b1;
          t_val = CNT_W'(WP_CYC - 1);
        end
      end
      DPSC_WPULSE: begin
        if (t_done) begin
          // The strobe and select rise together; recovery counts from here.
          st_nxt = DPSC_WREC;
          we_n_nxt = 1'b1;
          cs_n_nxt = 1'b1;
          ts_n_nxt = 1'b1;
          t_load = 1'b1;
          t_val = CNT_W'(WREC_CYC);
        end
      end
      DPSC_WREC: begin
        if (t_done) begin
          doe_nxt = 1'b0;
          ub_n_nxt = 1'b1;
          lb_n_nxt = 1'b1;
          if (chk_r) begin
            // Chip select stays high across the token write and check read.
            st_nxt = DPSC_GAP;
            t_load = 1'b1;
            t_val = CNT_W'(SWRD_CYC);
          end else begin
            st_nxt = DPSC_RDEND;
          end
        end
      end
      DPSC_GAP: begin
        if (t_done) begin
          // Check read starts after the flag write-to-read separation.
          st_nxt = DPSC_RD;
          ts_n_nxt = 1'b0;
          oe_n_nxt = 1'b0;
          ub_n_nxt = 1'b0;
          lb_n_nxt = 1'b0;
          t_load = 1'b1;
          t_val = CNT_W'(RD_CYC + 2);
        end
      end
      DPSC_RD: begin
        if (t_done) begin
          // Sample only after the slowest access limit plus the sync delay.
          if (din_s2_r == din_s3_r) begin
            rdat_nxt = din_s3_r;
            // Any data line shows the flag value; zero means this port holds it.
            gr_nxt = tok_r && !din_s3_r[0];
            st_nxt = DPSC_RDEND;
            cs_n_nxt = 1'b1;
            ts_n_nxt = 1'b1;
            oe_n_nxt = 1'b1;
            ub_n_nxt = 1'b1;
            lb_n_nxt = 1'b1;
          end
        end
      end
      DPSC_RDEND: begin
        // Response pulses once the pins are back at rest.
        st_nxt = DPSC_IDLE;
        rv_nxt = 1'b1;
        if (!tok_r) begin
          gr_nxt = 1'b0;
        end
      end
      default: begin
        st_nxt = DPSC_IDLE;
      end
    endcase
  end

  // Register the sequencer and pin state.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_r <= DPSC_IDLE;
      cs_n_r <= 1'b1;
      ts_n_r <= 1'b1;
      we_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      ub_n_r <= 1'b1;
      lb_n_r <= 1'b1;
      doe_r <= 1'b0;
      addr_r <= RESET_ADDR;
      dout_r <= RESET_DATA;
      rdat_r <= RESET_DATA;
      rv_r <= 1'b0;
      gr_r <= 1'b0;
      tok_r <= 1'b0;
      chk_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cs_n_r <= cs_n_nxt;
      ts_n_r <= ts_n_nxt;
      we_n_r <= we_n_nxt;
      oe_n_r <= oe_n_nxt;
      ub_n_r <= ub_n_nxt;
      lb_n_r <= lb_n_nxt;
      doe_r <= doe_nxt;
      addr_r <= addr_nxt;
      dout_r <= dout_nxt;
      rdat_r <= rdat_nxt;
      rv_r <= rv_nxt;
      gr_r <= gr_nxt;
      tok_r <= tok_nxt;
      chk_r <= chk_nxt;
    end
  end

  assign cmd_ready = st_r[0]; // One-hot idle bit, so ready comes straight from a flop.
  assign chip_select_n = cs_n_r;
  assign token_space_select_n = ts_n_r;
  assign write_strobe_n = we_n_r;
  assign output_enable_n = oe_n_r;
  assign upper_byte_select_n = ub_n_r;
  assign lower_byte_select_n = lb_n_r;
  assign addr = addr_r;
  assign data_out = dout_r;
  assign data_oe = doe_r;
  assign rsp_valid = rv_r;
  assign rsp_rdata = rdat_r;
  assign rsp_granted = gr_r;

  // Address never changes while a strobe or select is low.
  a_addr_stable: assert property (@(posedge ref_clk) disable iff (reset)
    (addr_r != $past(addr_r)) |-> ($past(cs_n_r) && $past(ts_n_r) && $past(we_n_r)))
    else $error("address changed during an active cycle");
  // Never both spaces selected together.
  a_space_excl: assert property (@(posedge ref_clk) disable iff (reset)
    !(!cs_n_r && !ts_n_r))
    else $error("array and token space selected together");
  // Data drive only while the RAM output enable is high.
  a_no_fight: assert property (@(posedge ref_clk) disable iff (reset)
    doe_r |-> oe_n_r)
    else $error("data driven while the RAM may drive");
  sequence s_wr_start;
    $fell(we_n_r);
  endsequence
  // Write pulse lasts exactly its cycle count.
  a_wp_width: assert property (@(posedge ref_clk) disable iff (reset)
    s_wr_start |-> (!we_n_r && doe_r) [*1] ##(WP_CYC) $rose(we_n_r))
    else $error("write pulse width wrong");
  // Select falls with the strobe, never before.
  a_sel_with_we: assert property (@(posedge ref_clk) disable iff (reset)
    s_wr_start |-> (!cs_n_r || !ts_n_r) && $past(cs_n_r) && $past(ts_n_r))
    else $error("select not aligned with strobe");
  // Data holds past the end of the write.
  a_wr_recov: assert property (@(posedge ref_clk) disable iff (reset)
    $rose(we_n_r) |-> doe_r && $stable(dout_r))
    else $error("data released at end of write");
  // Token check keeps chip select high throughout.
  a_tok_cs_high: assert property (@(posedge ref_clk) disable iff (reset)
    (tok_r && st_r != DPSC_IDLE && st_r != DPSC_SETUP) |-> cs_n_r)
    else $error("chip select low in token sequence");
  // Check read begins only after the separation gap.
  a_tok_gap: assert property (@(posedge ref_clk) disable iff (reset)
    (st_r == DPSC_GAP) ##1 (st_r == DPSC_RD) |-> $past(st_r, SWRD_CYC + 1) == DPSC_GAP)
    else $error("token read too soon");
  // Read sample waits the full access window.
  a_rd_wait: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(oe_n_r) |-> !oe_n_r [*3])
    else $error("read released too early");
endmodule

/* design/dpsc_pkg.sv */
// Package with pin timing constants and command codes for the dual-port SRAM port controller.
package dpsc_pkg;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // Slowest speed grade figures, in nanoseconds.
  localparam int unsigned T_WP_NS = 40;
  localparam int unsigned T_WZ_NS = 25;
  localparam int unsigned T_DW_NS = 30;
  localparam int unsigned T_WC_NS = 55;
  localparam int unsigned T_SWRD_NS = 5;
  localparam int unsigned T_ACC_NS = 65;
  localparam int unsigned T_BDD_NS = 50;
  localparam int unsigned T_HZ_NS = 25;
  // Least times round up to whole cycles, none below one.
  localparam int unsigned T_WP_RAW = (((T_WZ_NS + T_DW_NS) > T_WP_NS) ? (T_WZ_NS + T_DW_NS) : T_WP_NS);
  localparam int unsigned WP_CYC = (T_WP_RAW + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WREC_RAW = (T_WC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WREC_CYC = (WREC_RAW < 1) ? 1 : WREC_RAW;
  localparam int unsigned SWRD_CYC = ((T_SWRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                                     (T_SWRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned ACC_MAX_NS = (T_ACC_NS > T_BDD_NS) ? T_ACC_NS : T_BDD_NS;
  localparam int unsigned RD_CYC = (ACC_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HZ_CYC = ((T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS < 1) ? 1 :
                                   (T_HZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  // Command codes.
  localparam logic [1:0] CMD_RD = 2'h0;
  localparam logic [1:0] CMD_WR = 2'h1;
  localparam logic [1:0] CMD_TOKEN_GET = 2'h2;
  localparam logic [1:0] CMD_TOKEN_FREE = 2'h3;
  localparam logic [15:0] RESET_DATA = 16'h0000;
  localparam logic [14:0] RESET_ADDR = 15'h0000;
endpackage

/* design/dpsc_cycle_timer.sv */
// Down counter that times one phase of a pin cycle.
module dpsc_cycle_timer #(
  parameter int unsigned WIDTH = 4
) (
  // Clock and reset.
  input wire logic ref_clk,
  input wire logic reset,
  // Load and status.
  input wire logic load,
  input wire logic [WIDTH-1:0] load_val,
  output logic done
);
  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  // A load takes priority over counting so a new phase starts cleanly.
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - 1'b1;
    end
  end

  // Register the count.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  // Done depends on the count alone, since callers derive their load from it.
  assign done = (cnt_r == '0);
endmodule

/* verif/dpsc_sram_model.sv */
// Behavioural model of one RAM port with its token flags and a pin discipline monitor.
module dpsc_sram_model #(
  parameter int unsigned RD_LAT = 1
) (
  // Sampling clock.
  input wire logic ref_clk,
  // Port pins.
  input wire logic chip_select_n,
  input wire logic token_space_select_n,
  input wire logic write_strobe_n,
  input wire logic output_enable_n,
  input wire logic upper_byte_select_n,
  input wire logic lower_byte_select_n,
  input wire logic [14:0] addr,
  input wire logic [15:0] data_out,
  input wire logic data_oe,
  output logic [15:0] data_in,
  // Flags held by the far port, and a misuse flag.
  input wire logic [7:0] far_owns,
  output logic misuse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:255];
  logic [7:0] flag = 8'hFF;
  logic [15:0] val;
  logic [15:0] last = 16'h0000;
  logic [14:0] addr_q = 15'h0000;
  int unsigned age = 0;
  logic rd;
  // Drives only while the strobe is high, so a select falling with the strobe leaves the pins floating.
  assign rd = (!chip_select_n || !token_space_select_n) && !output_enable_n && write_strobe_n;
  // Token space shows the flag on all lines; array words are only 256 deep here.
  assign val = !token_space_select_n ? {16{flag[addr[2:0]]}} : mem[addr[7:0]];
  // Before access time the pins show the inverse of the last value, so stale data cannot pass.
  // No far-port write to the same word is modelled, so reads never wait on the busy path.
  assign data_in = (rd && age >= RD_LAT) ? val : ~last;
  // Store on the select and strobe overlap, and flag any pin misuse by the controller.
  always @(posedge ref_clk) begin
    age <= rd ? age + 1 : 0;
    if (rd && age >= RD_LAT) last <= val;
    if (!chip_select_n && !write_strobe_n) begin
      if (!upper_byte_select_n) mem[addr[7:0]][15:8] <= data_out[15:8];
      if (!lower_byte_select_n) mem[addr[7:0]][7:0] <= data_out[7:0];
    end
    // A claim held by the far port wins, one of the outcomes a contention may give.
    if (!token_space_select_n && !write_strobe_n && !(!data_out[0] && far_owns[addr[2:0]])) begin
      flag[addr[2:0]] <= data_out[0];
    end
    misuse <= (!chip_select_n && !token_space_select_n)
      || (addr != addr_q && !write_strobe_n && !(chip_select_n && token_space_select_n)
          && !(upper_byte_select_n && lower_byte_select_n))
      || (data_oe && rd);
    addr_q <= addr;
  end
endmodule

/* verif/dpsc_port_ctrl_test.sv */
// Self-checking bench for the port controller against the RAM port model.
module dpsc_port_ctrl_test;
  timeunit 1ns;
  timeprecision 1ps;
  import dpsc_pkg::*;
  typedef struct {logic [1:0] op; logic [15:0] data; logic grant;} dpsc_exp_s;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic cmd_valid = 1'b0;
  logic [1:0] cmd_op = 2'h0;
  logic [14:0] cmd_addr = 15'h0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [1:0] cmd_be = 2'h0;
  logic [7:0] far_owns = 8'h00;
  logic cmd_ready, rsp_valid, rsp_granted, data_oe, misuse;
  logic chip_select_n, token_space_select_n, write_strobe_n, output_enable_n;
  logic upper_byte_select_n, lower_byte_select_n;
  logic [14:0] addr;
  logic [15:0] rsp_rdata, data_out, data_in;
  logic [15:0] ref_mem [0:15];
  dpsc_exp_s expq[$];
  dpsc_exp_s e;
  int miscompares = 0;
  int n_checks = 0;
  int seed = 76;
  int r, a, k;
  dpsc_port_ctrl dpsc_port_ctrl_inst (.ref_clk, .reset, .cmd_valid, .cmd_op, .cmd_addr, .cmd_wdata, .cmd_be,
    .cmd_ready, .rsp_valid, .rsp_rdata, .rsp_granted, .chip_select_n, .token_space_select_n, .write_strobe_n,
    .output_enable_n, .upper_byte_select_n, .lower_byte_select_n, .addr, .data_out, .data_oe, .data_in);
  dpsc_sram_model #(.RD_LAT(RD_CYC)) dpsc_sram_model_inst (.ref_clk, .chip_select_n, .token_space_select_n,
    .write_strobe_n,
    .output_enable_n, .upper_byte_select_n, .lower_byte_select_n, .addr, .data_out, .data_oe, .data_in,
    .far_owns, .misuse);
  // Free-running 20 MHz clock.
  initial begin
    forever #25 ref_clk = ~ref_clk;
  end
  task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_data({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Presents one command and holds it until the controller takes it.
  task automatic issue(input logic [1:0] op, input int ad, input logic [15:0] d, input logic [1:0] be,
                       input logic [15:0] ed, input logic eg);
    int i;
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_op = op;
    cmd_addr = ad[14:0];
    cmd_wdata = d;
    cmd_be = be;
    expq.push_back('{op, ed, eg});
    i = 0;
    while (cmd_ready !== 1'b1 && i < 200) begin
      @(negedge ref_clk);
      i++;
    end
    if (cmd_ready !== 1'b1) begin
      miscompares++;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
  endtask
  // Waits, within a bound, until every noted result has come back.
  task automatic drain();
    int i;
    i = 0;
    while (expq.size() != 0 && i < 400) begin
      @(negedge ref_clk);
      i++;
    end
    if (expq.size() != 0) begin
      miscompares++;
    end
  endtask
  // Idle pin levels after reset: all strobes high, data released, ready up.
  task automatic check_idle();
    chk_data({7'h00, chip_select_n, token_space_select_n, write_strobe_n, output_enable_n, upper_byte_select_n,
      lower_byte_select_n, data_oe, cmd_ready, rsp_valid}, 16'h01FA);
  endtask
  // Each response retires the oldest note; pin misuse is checked every cycle.
  always @(negedge ref_clk) begin
    if (!reset) begin
      chk_bit(misuse, 1'b0);
      if (rsp_valid === 1'b1 && expq.size() == 0) begin
        chk_bit(rsp_valid, 1'b0);
      end else if (rsp_valid === 1'b1) begin
        e = expq.pop_front();
        if (e.op == CMD_RD) begin
          chk_data(rsp_rdata, e.data);
          chk_bit(rsp_granted, 1'b0);
        end else if (e.op == CMD_TOKEN_GET) begin
          chk_data(rsp_rdata, e.data);
          chk_bit(rsp_granted, e.grant);
        end
      end
    end
  end
  // Main sequence: fill, random traffic, tokens, reset during a write's setup phase, before the strobe falls.
  initial begin
    repeat (20) @(negedge ref_clk);
    check_idle();
    reset = 1'b0;
    for (a = 0; a < 16; a++) begin
      r = $random(seed);
      ref_mem[a] = r[15:0];
      issue(CMD_WR, a, ref_mem[a], 2'h3, 16'h0000, 1'b0);
    end
    // Byte enables include none and one lane, so unselected lanes must keep old data.
    for (k = 0; k < 30; k++) begin
      r = $random(seed);
      a = r[3:0];
      if (r[4]) begin
        issue(CMD_WR, a, r[31:16], r[6:5], 16'h0000, 1'b0);
        if (r[6]) ref_mem[a][15:8] = r[31:24];
        if (r[5]) ref_mem[a][7:0] = r[23:16];
      end else begin
        issue(CMD_RD, a, 16'h0000, 2'h3, ref_mem[a], 1'b0);
      end
    end
    issue(CMD_TOKEN_GET, 3, 16'h0000, 2'h3, 16'h0000, 1'b1);
    issue(CMD_TOKEN_GET, 3, 16'h0000, 2'h3, 16'h0000, 1'b1);
    issue(CMD_TOKEN_FREE, 3, 16'h0000, 2'h3, 16'h0000, 1'b0);
    far_owns = 8'h20;
    issue(CMD_TOKEN_GET, 5, 16'h0000, 2'h3, 16'hFFFF, 1'b0);
    drain();
    far_owns = 8'h00;
    issue(CMD_TOKEN_GET, 5, 16'h0000, 2'h3, 16'h0000, 1'b1);
    issue(CMD_TOKEN_FREE, 5, 16'h0000, 2'h3, 16'h0000, 1'b0);
    issue(CMD_RD, 3, 16'h0000, 2'h3, ref_mem[3], 1'b0);
    issue(CMD_WR, 32, 16'hA5A5, 2'h3, 16'h0000, 1'b0);
    @(negedge ref_clk);
    reset = 1'b1;
    expq.delete();
    repeat (3) @(negedge ref_clk);
    check_idle();
    reset = 1'b0;
    issue(CMD_RD, 1, 16'h0000, 2'h3, ref_mem[1], 1'b0);
    drain();
    tally_and_finish();
  end
endmodule
